/* File: design/fd_timing_pkg.sv */
/*
 * Constants for the timestamp counter and fast-phase bit timing block.
 * Assumes a 125 MHz CAN clock and a plain one-cycle register port.
 */
package fd_timing_pkg;
    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_STAMP      = 8'h28;
    localparam logic [7:0] OFS_PRESCALE   = 8'h88;
    localparam logic [7:0] OFS_SEGMENT    = 8'h8c;
    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int STAMP_LSB        = 16;
    localparam int CLEAR_BIT        = 0;
    localparam int COMP_EN_BIT      = 16;
    localparam int COMP_OFS_LSB     = 8;
    localparam int PRESCALER_LSB    = 0;
    localparam int JUMP_LSB         = 16;
    localparam int SEG_TWO_LSB      = 8;
    localparam int SEG_ONE_LSB      = 0;
    // ------------------------------------------------------------------
    // Reset values and counts
    // ------------------------------------------------------------------
    localparam logic [15:0] STAMP_RESET    = 16'h0000;
    localparam logic [3:0]  TICK_LAST      = 4'hf;
    localparam logic [6:0]  COMP_MAX       = 7'h7f;
    localparam logic [31:0] REG_RESET      = 32'h0000_0000;
endpackage : fd_timing_pkg

/* File: design/stamp_counter.sv */
/*
 * Free-running timestamp counter with prescale by sixteen.
 * Assumes clear request and enable come from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module stamp_counter
    import fd_timing_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        clear_req,
    input  wire logic        enable,
    output logic [15:0]      stamp_counter_value
);
    logic [3:0]  tick_r;
    logic [3:0]  tick_nxt;
    logic [15:0] count_nxt;
    wire         tick_done = (tick_r == TICK_LAST);
    wire         hold_zero = clear_req | ~enable;

    assign tick_nxt  = hold_zero ? 4'h0 : tick_r + 4'h1;
    // Roll over all-ones to zero silently
    assign count_nxt = hold_zero ? STAMP_RESET :
                       (tick_done ? stamp_counter_value + 16'h0001 : stamp_counter_value);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_r              <= 4'h0;
            stamp_counter_value <= STAMP_RESET;
        end else begin
            tick_r              <= tick_nxt;
            stamp_counter_value <= count_nxt;
        end
    end

    a_stamp_step: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $past(!hold_zero) && $past(tick_done) && !$past(hold_zero, 1)
        |-> stamp_counter_value == $past(stamp_counter_value) + 16'h0001)
        else $error("stamp did not step after sixteen cycles");
    a_stamp_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $past(!hold_zero) && !$past(tick_done)
        |-> stamp_counter_value == $past(stamp_counter_value))
        else $error("stamp moved between ticks");
    a_stamp_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $past(hold_zero) |-> stamp_counter_value == 16'h0000)
        else $error("stamp not cleared");
    a_stamp_wrap: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $past(!hold_zero) && $past(tick_done) && $past(stamp_counter_value) == 16'hffff
        |-> stamp_counter_value == 16'h0000)
        else $error("stamp wrap wrong");
    c_stamp_wrap: cover property (@(posedge sys_clk) disable iff (!rst_n)
        stamp_counter_value == 16'hffff ##1 stamp_counter_value == 16'h0000);
endmodule : stamp_counter
`default_nettype wire

/* File: design/fd_timing_regs.sv */
/*
 * Timestamp register and fast-phase bit timing registers of a CAN FD controller.
 * Assumes the enable bit, SOF/ID start, frame-ok and loop delay come from the
 * protocol engine on sys_clk; register port is one-cycle strobe style.
 */
//
// Overview of operation
// - Sixteen-bit timestamp counter steps once per sixteen CAN clocks.
// - Counter sampled when identifier field starts after start-of-frame.
// - Sampled stamp goes to DLC word on good receive or transmit.
// - Counter wrap raises no flag of any kind.
// - Running count readable in bits 31:16; cleared while controller disabled.
// - Writing 1 to bit 0 clears the counter; bit reads 0.
// - Bit 16 of prescale register enables delay compensation.
// - Five-bit offset in bits 12:8 added to measured loop delay.
// - Bits 7:0 prescaler; effective factor is value plus one.
// - Bits 18:16 jump width; used as value plus one quanta.
// - Bits 10:8 segment two; used as value plus one quanta.
// - Bits 3:0 segment one; used as value plus one quanta.
// - Timing fields writable only while controller enable is 0.
// - Loop delay plus offset saturates at 127 CAN clocks.
`timescale 1ns/1ps
`default_nettype none
module fd_timing_regs
    import fd_timing_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata,
    input  wire logic        controller_enable_bit,
    input  wire logic        id_field_start,
    input  wire logic        frame_ok,
    input  wire logic [6:0]  loop_delay,
    output logic [15:0]      dlc_stamp,
    output logic             dlc_stamp_wr,
    output logic             delay_comp_en,
    output logic [6:0]       delay_comp_total,
    output logic [8:0]       fast_phase_prescaler,
    output logic [3:0]       fast_phase_jump_width,
    output logic [3:0]       fast_phase_segment_two,
    output logic [4:0]       fast_phase_segment_one
);
    // ------------------------------------------------------------------
    // Stored fields
    // ------------------------------------------------------------------
    logic        comp_en_r;
    logic [4:0]  delay_comp_offset_r;
    logic [7:0]  prescaler_r;
    logic [2:0]  jump_r;
    logic [2:0]  seg_two_r;
    logic [3:0]  seg_one_r;
    logic [15:0] sample_r;
    logic [15:0] stamp_counter_value;
    logic [31:0] rdata_nxt;
    logic [7:0]  comp_sum;

    // ------------------------------------------------------------------
    // Decoded field arithmetic
    // ------------------------------------------------------------------
    // Prescaler, jump width and both segments are used as stored value plus one;
    // one adder shape for all of them keeps the four outputs consistent.
    function automatic logic [8:0] plus_one(input logic [7:0] raw);
        return {1'b0, raw} + 9'h001;
    endfunction : plus_one

    wire [8:0] prescale_dec = plus_one(prescaler_r);
    wire [8:0] jump_dec     = plus_one({5'h00, jump_r});
    wire [8:0] seg_two_dec  = plus_one({5'h00, seg_two_r});
    wire [8:0] seg_one_dec  = plus_one({4'h0, seg_one_r});

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    wire hit_stamp    = (reg_addr == OFS_STAMP);
    wire hit_prescale = (reg_addr == OFS_PRESCALE);
    wire hit_segment  = (reg_addr == OFS_SEGMENT);
    // Timing fields are frozen while the engine runs on them
    wire cfg_open     = ~controller_enable_bit;
    wire wr_prescale  = reg_wr & hit_prescale & cfg_open;
    wire wr_segment   = reg_wr & hit_segment & cfg_open;
    wire clear_stamp  = reg_wr & hit_stamp & reg_wdata[CLEAR_BIT];

    stamp_counter u_stamp (
        .sys_clk             (sys_clk),
        .rst_n               (rst_n),
        .clear_req           (clear_stamp),
        .enable              (controller_enable_bit),
        .stamp_counter_value (stamp_counter_value)
    );

    // Clear bit reads 0, no wrap flag exists
    assign rdata_nxt =
        hit_stamp    ? {stamp_counter_value, 16'h0000} :
        hit_prescale ? {15'h0000, comp_en_r, 3'h0, delay_comp_offset_r, prescaler_r} :
        hit_segment  ? {13'h0000, jump_r, 5'h00, seg_two_r, 4'h0, seg_one_r} :
                       REG_RESET;

    // Saturating sum of loop delay and offset
    assign comp_sum = {1'b0, loop_delay} + {3'h0, delay_comp_offset_r};

    // ------------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= REG_RESET;
        end else begin
            reg_rdata <= reg_rd ? rdata_nxt : REG_RESET;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            comp_en_r           <= 1'b0;
            delay_comp_offset_r <= 5'h00;
            prescaler_r         <= 8'h00;
        end else if (wr_prescale) begin
            comp_en_r           <= reg_wdata[COMP_EN_BIT];
            delay_comp_offset_r <= reg_wdata[COMP_OFS_LSB +: 5];
            prescaler_r         <= reg_wdata[PRESCALER_LSB +: 8];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            jump_r    <= 3'h0;
            seg_two_r <= 3'h0;
            seg_one_r <= 4'h0;
        end else if (wr_segment) begin
            jump_r    <= reg_wdata[JUMP_LSB +: 3];
            seg_two_r <= reg_wdata[SEG_TWO_LSB +: 3];
            seg_one_r <= reg_wdata[SEG_ONE_LSB +: 4];
        end
    end

    // ------------------------------------------------------------------
    // Timestamp capture and engine outputs
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sample_r     <= STAMP_RESET;
            dlc_stamp    <= STAMP_RESET;
            dlc_stamp_wr <= 1'b0;
        end else begin
            if (id_field_start) begin
                sample_r <= stamp_counter_value;
            end
            if (frame_ok) begin
                dlc_stamp <= sample_r;
            end
            dlc_stamp_wr <= frame_ok;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            delay_comp_en          <= 1'b0;
            delay_comp_total       <= 7'h00;
            fast_phase_prescaler   <= 9'h001;
            fast_phase_jump_width  <= 4'h1;
            fast_phase_segment_two <= 4'h1;
            fast_phase_segment_one <= 5'h01;
        end else begin
            delay_comp_en          <= comp_en_r;
            delay_comp_total       <= comp_sum[7] ? COMP_MAX : comp_sum[6:0];
            fast_phase_prescaler   <= prescale_dec;
            fast_phase_jump_width  <= jump_dec[3:0];
            fast_phase_segment_two <= seg_two_dec[3:0];
            fast_phase_segment_one <= seg_one_dec[4:0];
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_locked_fields: assert property (@(posedge sys_clk) disable iff (!rst_n)
        reg_wr && hit_prescale && controller_enable_bit
        |=> prescaler_r == $past(prescaler_r) && comp_en_r == $past(comp_en_r))
        else $error("prescale fields changed while enabled");
    a_locked_segment: assert property (@(posedge sys_clk) disable iff (!rst_n)
        reg_wr && hit_segment && controller_enable_bit
        |=> {jump_r, seg_two_r, seg_one_r} == $past({jump_r, seg_two_r, seg_one_r}))
        else $error("segment fields changed while enabled");
    a_open_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wr_prescale |=> ##1 fast_phase_prescaler == {1'b0, $past(reg_wdata[7:0], 2)} + 9'h001)
        else $error("prescaler not value plus one");
    a_segment_one: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wr_segment |=> ##1 fast_phase_segment_one == {1'b0, $past(reg_wdata[3:0], 2)} + 5'h01)
        else $error("segment one not value plus one");
    a_comp_sat: assert property (@(posedge sys_clk) disable iff (!rst_n)
        comp_sum > 8'd127 |=> delay_comp_total == 7'h7f)
        else $error("compensation not saturated");
    a_comp_sum: assert property (@(posedge sys_clk) disable iff (!rst_n)
        comp_sum <= 8'd127 |=> delay_comp_total == $past(comp_sum[6:0]))
        else $error("compensation sum wrong");
    a_stamp_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
        reg_rd && hit_stamp |=> reg_rdata[15:0] == 16'h0000
        && reg_rdata[31:16] == $past(stamp_counter_value))
        else $error("stamp read wrong");
    a_dlc_stamp: assert property (@(posedge sys_clk) disable iff (!rst_n)
        frame_ok && !id_field_start |=> dlc_stamp_wr && dlc_stamp == $past(sample_r))
        else $error("dlc stamp wrong");
    a_id_sample: assert property (@(posedge sys_clk) disable iff (!rst_n)
        id_field_start |=> sample_r == $past(stamp_counter_value))
        else $error("sample not taken at id start");

    a_sample_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !id_field_start |=> sample_r == $past(sample_r))
        else $error("sample moved without id start");

    a_dlc_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !frame_ok |=> !dlc_stamp_wr && dlc_stamp == $past(dlc_stamp))
        else $error("dlc stamp moved without frame");

    a_jump_width: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wr_segment |=> ##1 fast_phase_jump_width == {1'b0, $past(reg_wdata[18:16], 2)} + 4'h1)
        else $error("jump width not value plus one");

    a_segment_two: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wr_segment |=> ##1 fast_phase_segment_two == {1'b0, $past(reg_wdata[10:8], 2)} + 4'h1)
        else $error("segment two not value plus one");

    a_comp_enable: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wr_prescale |=> ##1 delay_comp_en == $past(reg_wdata[16], 2))
        else $error("compensation enable not taken");

    a_offset_store: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wr_prescale |=> delay_comp_offset_r == $past(reg_wdata[12:8]))
        else $error("compensation offset not stored");

    a_prescale_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !wr_prescale |=> delay_comp_offset_r == $past(delay_comp_offset_r)
        && prescaler_r == $past(prescaler_r) && comp_en_r == $past(comp_en_r))
        else $error("prescale fields changed without write");

    a_segment_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !wr_segment |=> {jump_r, seg_two_r, seg_one_r} == $past({jump_r, seg_two_r, seg_one_r}))
        else $error("segment fields changed without write");

    a_stamp_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !controller_enable_bit |=> stamp_counter_value == 16'h0000)
        else $error("stamp runs while disabled");

    a_stamp_cleared: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clear_stamp |=> stamp_counter_value == 16'h0000)
        else $error("stamp not cleared by write");

    // Read data only stands in the cycle after the strobe; idle bus reads zero
    a_rdata_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !reg_rd |=> reg_rdata == 32'h0000_0000)
        else $error("read data not zero when idle");

    a_unmapped_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
        reg_rd && !hit_stamp && !hit_prescale && !hit_segment |=> reg_rdata == 32'h0000_0000)
        else $error("unmapped read not zero");

    c_locked_write: cover property (@(posedge sys_clk) disable iff (!rst_n)
        reg_wr && hit_segment && controller_enable_bit);
    c_open_write: cover property (@(posedge sys_clk) disable iff (!rst_n) wr_prescale);
    c_frame: cover property (@(posedge sys_clk) disable iff (!rst_n)
        id_field_start ##[1:200] frame_ok);
    c_saturate: cover property (@(posedge sys_clk) disable iff (!rst_n) comp_sum[7]);
endmodule : fd_timing_regs
`default_nettype wire

/* File: dv/engine_model.sv */
/*
 * Model of the protocol engine beside the timing registers: identifier-start
 * and frame-done pulses, plus a measured loop delay.
 * Assumes go is a one-cycle request on sys_clk from the bench.
 */
`timescale 1ns/1ps
`default_nettype none
module engine_model (
    input  wire logic       sys_clk,
    input  wire logic       go,
    input  wire logic [7:0] gap,
    input  wire logic [6:0] dly,
    output var  logic       id_field_start,
    output var  logic       frame_ok,
    output var  logic [6:0] loop_delay
);
    logic [7:0] left_r;
    initial begin
        id_field_start = 1'b0;
        frame_ok = 1'b0;
        loop_delay = 7'h00;
        left_r = 8'h00;
    end
    // Bench drives delay plus offset past 127 to reach saturation; no bit-time check here
    always @(posedge sys_clk) begin
        id_field_start <= go;
        frame_ok <= (left_r == 8'h01);
        left_r <= go ? gap : ((left_r != 8'h00) ? left_r - 8'h01 : 8'h00);
        loop_delay <= dly;
    end
endmodule : engine_model
`default_nettype wire

/* File: dv/canfd_timestamp_data_bit_timing_bench.sv */
/*
 * Self-checking bench for the timestamp and fast-phase timing registers.
 * Assumes the engine model stands in for the protocol engine.
 */
`timescale 1ns/1ps
`default_nettype none
module canfd_timestamp_data_bit_timing_bench;
    import fd_timing_pkg::*;
    logic sys_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, en = 1'b0, go = 1'b0;
    logic [7:0]  reg_addr = 8'h00, gap = 8'h00;
    logic [6:0]  dly = 7'h00;
    logic [31:0] reg_wdata = 32'h0, a, b;
    logic [31:0] reg_rdata;
    logic        id_start, f_ok, c_en, s_wr;
    logic [6:0]  l_dly, c_tot;
    logic [15:0] s_val;
    logic [8:0]  pre;
    logic [3:0]  jw, s2;
    logic [4:0]  s1;
    int fails = 0, cmp_count = 0;
    always #4 sys_clk = ~sys_clk;
    engine_model ENG (.sys_clk(sys_clk), .go(go), .gap(gap), .dly(dly),
        .id_field_start(id_start), .frame_ok(f_ok), .loop_delay(l_dly));
    fd_timing_regs DUT (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .controller_enable_bit(en), .id_field_start(id_start), .frame_ok(f_ok),
        .loop_delay(l_dly), .dlc_stamp(s_val), .dlc_stamp_wr(s_wr), .delay_comp_en(c_en),
        .delay_comp_total(c_tot), .fast_phase_prescaler(pre), .fast_phase_jump_width(jw),
        .fast_phase_segment_two(s2), .fast_phase_segment_one(s1));
    // ------------------------------------------------------------------
    // Bus and compare helpers
    // ------------------------------------------------------------------
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= ad;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] ad, output logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= ad;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_le(input logic [31:0] got, input logic [31:0] lim);
        cmp_count++;
        if (!(got <= lim) || $isunknown(got)) begin
            fails++;
            $display("BAD t=%0t got=%h lim=%h", $time, got, lim);
        end
    endtask : chk_le
    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : give_verdict
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        rd(OFS_PRESCALE, a); chk(a, 32'h0);
        rd(OFS_SEGMENT, a); chk(a, 32'h0);
        rd(OFS_STAMP, a); chk(a, 32'h0);
        rd(8'h40, a); chk(a, 32'h0);
        chk({pre, jw, s2, s1, c_en, 9'h0}, {9'h001, 4'h1, 4'h1, 5'h01, 1'b0, 9'h0});
    endtask : t_reset
    task automatic t_timing;
        wr(OFS_PRESCALE, 32'hffff_ffff);
        wr(OFS_SEGMENT, 32'hffff_ffff);
        rd(OFS_PRESCALE, a); chk(a, 32'h0001_1fff);
        rd(OFS_SEGMENT, a); chk(a, 32'h0007_070f);
        chk({pre, jw, s2, s1, c_en, 9'h0}, {9'h100, 4'h8, 4'h8, 5'h10, 1'b1, 9'h0});
        en <= 1'b1;
        wr(OFS_PRESCALE, 32'h0);
        wr(OFS_SEGMENT, 32'h0);
        rd(OFS_PRESCALE, a); chk(a, 32'h0001_1fff);
        rd(OFS_SEGMENT, a); chk(a, 32'h0007_070f);
        chk({pre, jw, s2, s1, c_en, 9'h0}, {9'h100, 4'h8, 4'h8, 5'h10, 1'b1, 9'h0});
        en <= 1'b0;
    endtask : t_timing
    task automatic t_comp;
        logic [6:0] dl [5] = '{7'd0, 7'd10, 7'd96, 7'd97, 7'd127};
        logic [6:0] ex [5] = '{7'd31, 7'd41, 7'd127, 7'd127, 7'd127};
        foreach (dl[i]) begin
            @(posedge sys_clk);
            dly <= dl[i];
            repeat (4) @(posedge sys_clk);
            #1 chk({25'h0, c_tot}, {25'h0, ex[i]});
        end
    endtask : t_comp
    task automatic t_count;
        en <= 1'b1;
        repeat (200) @(posedge sys_clk);
        wr(OFS_STAMP, 32'h1);
        rd(OFS_STAMP, a); chk_le({16'h0, a[31:16]}, 32'h1);
        chk({16'h0, a[15:0]}, 32'h0);
        rd(OFS_STAMP, a);
        repeat (158) @(posedge sys_clk);
        rd(OFS_STAMP, b); chk({16'h0, b[31:16] - a[31:16]}, 32'ha);
        en <= 1'b0;
        repeat (40) @(posedge sys_clk);
        rd(OFS_STAMP, a); chk(a, 32'h0);
    endtask : t_count
    task automatic t_stamp;
        en <= 1'b1;
        repeat (100) @(posedge sys_clk);
        rd(OFS_STAMP, a);
        gap <= 8'd100;
        go <= 1'b1;
        @(posedge sys_clk);
        go <= 1'b0;
        for (int i = 0; i < 300 && s_wr !== 1'b1; i++) @(negedge sys_clk);
        chk({31'h0, s_wr}, 32'h1);
        chk_le({16'h0, s_val - a[31:16]}, 32'h1);
        @(negedge sys_clk);
        chk({31'h0, s_wr}, 32'h0);
    endtask : t_stamp
    initial begin
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_reset();
        t_timing();
        t_comp();
        t_count();
        t_stamp();
        give_verdict();
    end
    initial begin
        #100us;
        fails++;
        give_verdict();
    end
endmodule : canfd_timestamp_data_bit_timing_bench
`default_nettype wire
